// >>> rtl/bss_boot_select.sv
// boot space select: strap sampling on hard reset, held over soft reset
`timescale 1ns/10ps

module bss_boot_select
    import bss_pkg::*;
(
    // clock and power-on / system reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // external reset pin request, already a clean pulse or level
    input  wire logic                 ext_rst_req,
    // soft reset sources
    input  wire logic                 soft_rst_req,
    input  wire logic                 prot_enable_req,
    // board strap pins
    input  wire bss_pkg::bss_straps_t straps,
    // results
    output bss_pkg::bss_space_t       boot_space,
    output logic [31:0]               fetch_alias_base,
    output logic                      core_rst,
    output logic                      space_valid
);
    import bss_pkg::*;

    // ************************************************************
    //  strap synchroniser
    // ************************************************************

    // three stages per strap; stage 0 feeds only stage 1
    logic [BSS_SYNC_DEPTH-1:0] prim_sync_q;
    logic [BSS_SYNC_DEPTH-1:0] sec_sync_q;
    logic                      prim_stable_q;  // accepted primary level
    logic                      sec_stable_q;   // accepted secondary level

    // shift the pins in every edge
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prim_sync_q <= '0;
            sec_sync_q  <= '0;
        end
        else
        begin
            prim_sync_q <= {prim_sync_q[BSS_SYNC_DEPTH-2:0],
                            straps.primary_boot_strap};
            sec_sync_q  <= {sec_sync_q[BSS_SYNC_DEPTH-2:0],
                            straps.secondary_boot_strap};
        end
    end

    // a change counts only once the last two stages agree
    wire prim_agree = prim_sync_q[BSS_SYNC_MID] == prim_sync_q[BSS_SYNC_LAST];
    wire sec_agree  = sec_sync_q[BSS_SYNC_MID] == sec_sync_q[BSS_SYNC_LAST];

    // hold the last agreed level
    // while stages 1 and 2 disagree the old level is kept, so a bouncing
    // pin never reaches the decode half-way through a change
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prim_stable_q <= 1'b0;
            sec_stable_q  <= 1'b0;
        end
        else
        begin
            if (prim_agree)
                prim_stable_q <= prim_sync_q[BSS_SYNC_LAST];
            if (sec_agree)
                sec_stable_q  <= sec_sync_q[BSS_SYNC_LAST];
        end
    end

    // ************************************************************
    //  strap decode
    // ************************************************************

    // primary low wins regardless of the secondary strap
    // limitation: a floating primary strap may settle at either level,
    // so the board needs a pull-down for a certain flash boot
    wire bss_space_t decoded_space =
        !prim_stable_q ? BSS_SPACE_FLASH :
        (sec_stable_q  ? BSS_SPACE_SRAM
                       : BSS_SPACE_SYSMEM);

    // ************************************************************
    //  reset sequencing
    // ************************************************************

    typedef enum logic [1:0]
    {
        BSS_ST_SAMPLE,   // hard reset: wait for straps, then latch
        BSS_ST_RUN,      // core running from latched space
        BSS_ST_SOFT      // soft reset pulse, no strap sampling
    } bss_state_t;

    bss_state_t  state_q;
    bss_state_t  state_d;
    logic [2:0]  settle_q;      // settle counter for strap latch
    logic [2:0]  settle_d;
    bss_space_t  space_q;       // latched boot space
    bss_space_t  space_d;
    logic        valid_q;       // a space has been latched since power-on
    logic        core_rst_q;    // reset to the core fetch path
    logic [31:0] alias_q;       // registered alias base

    // soft reset sources are merged; neither may reload the straps
    // the protection-enable reset is raised by the loader itself
    wire soft_any  = soft_rst_req | prot_enable_req;
    // the external pin restarts sampling from any state; it wins over soft
    wire hard_any  = ext_rst_req;
    wire settle_done = settle_q == BSS_SETTLE_CYC;

    // next-state decode
    always_comb
    begin
        state_d  = state_q;
        settle_d = settle_q;
        space_d  = space_q;
        case (state_q)
            BSS_ST_SAMPLE:
            begin
                // let the synchroniser refill before trusting the straps;
                // a pin still held keeps the count at its start, and the
                // straps are taken only once the count has run out
                if (hard_any)
                    settle_d = BSS_ZERO3;
                else if (settle_done)
                begin
                    space_d = decoded_space;
                    state_d = BSS_ST_RUN;
                end
                else
                    settle_d = settle_q + 3'h1;
            end
            BSS_ST_RUN:
            begin
                // a hard reset goes back to sampling; a soft or
                // protection reset only pulses the core and keeps
                // the space, so the loader cannot be left by it
                if (hard_any)
                begin
                    settle_d = BSS_ZERO3;
                    state_d  = BSS_ST_SAMPLE;
                end
                else if (soft_any)
                    state_d = BSS_ST_SOFT;
            end
            BSS_ST_SOFT:
            begin
                // one cycle of core reset; space_q left untouched
                // a hard reset still wins in this cycle
                if (hard_any)
                begin
                    settle_d = BSS_ZERO3;
                    state_d  = BSS_ST_SAMPLE;
                end
                else
                    state_d = BSS_ST_RUN;
            end
            default:
            begin
                // unused code: recover into a fresh strap sample
                settle_d = BSS_ZERO3;
                state_d  = BSS_ST_SAMPLE;
            end
        endcase
    end

    // alias base picked from the space that the core will restart in
    wire [31:0] alias_d =
        (space_d == BSS_SPACE_SYSMEM) ? BSS_BASE_SYSMEM :
        (space_d == BSS_SPACE_SRAM)   ? BSS_BASE_SRAM
                                      : BSS_BASE_FLASH;

    // core held in reset except while running
    wire core_rst_d = state_d != BSS_ST_RUN;

    // the one edge on which the straps become the latched space
    wire latch_now = (state_q == BSS_ST_SAMPLE) && (state_d == BSS_ST_RUN);

    // state registers; alias and core reset are registered here so that
    // every output of the block leaves a flip-flop
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q    <= BSS_ST_SAMPLE;
            settle_q   <= BSS_ZERO3;
            space_q    <= BSS_SPACE_RST;
            valid_q    <= 1'b0;
            core_rst_q <= 1'b1;
            alias_q    <= BSS_BASE_FLASH;
        end
        else
        begin
            state_q    <= state_d;
            settle_q   <= settle_d;
            space_q    <= space_d;
            core_rst_q <= core_rst_d;
            alias_q    <= alias_d;
            // valid is only ever set; only a power cycle clears it
            if (latch_now)
                valid_q <= 1'b1;
        end
    end

    // ************************************************************
    //  outputs, all straight from flip-flops
    // ************************************************************

    // space and alias stand until the next hard latch
    assign boot_space       = space_q;
    assign fetch_alias_base = alias_q;
    assign core_rst         = core_rst_q;
    assign space_valid      = valid_q;

endmodule

// >>> rtl/bss_pkg.sv
// package: boot space codes, strap carrier and reset-related constants
package bss_pkg;

    // boot space selected from the straps
    typedef enum logic [1:0]
    {
        BSS_SPACE_FLASH,
        BSS_SPACE_SYSMEM,
        BSS_SPACE_SRAM
    } bss_space_t;

    // the two strap pins travel together
    typedef struct packed
    {
        logic primary_boot_strap;
        logic secondary_boot_strap;
    } bss_straps_t;

    // value of the latched space after power-on reset
    localparam bss_space_t BSS_SPACE_RST = BSS_SPACE_FLASH;

    // alias base addresses of each space
    localparam logic [31:0] BSS_BASE_FLASH  = 32'h0800_0000;
    localparam logic [31:0] BSS_BASE_SYSMEM = 32'h1FFF_F000;
    localparam logic [31:0] BSS_BASE_SRAM   = 32'h2000_0000;

    // strap synchroniser depth and bit positions of its stages
    localparam int          BSS_SYNC_DEPTH  = 3;
    localparam int          BSS_SYNC_MID    = 1;
    localparam int          BSS_SYNC_LAST   = 2;

    // cycles for the straps to settle through the synchroniser after a
    // sampling reset is released before they are latched
    localparam logic [2:0]  BSS_SETTLE_CYC  = 3'h4;
    localparam logic [2:0]  BSS_ZERO3       = 3'h0;

endpackage

// >>> sim/bss_board_model.sv
// partner: board strap pins and external reset source
`timescale 1ns/10ps
module bss_board_model
    import bss_pkg::*;
(
    // clock of the block under test
    input  wire logic                clk,
    // strap pins and external reset pin
    output bss_pkg::bss_straps_t     straps,
    output logic                     ext_rst_req
);
    // straps start low, as with a pull-down on the primary strap
    initial straps = '0;
    initial ext_rst_req = 1'b0;
    // straps move just after an edge, never near the sampling edge
    task automatic set_straps(input logic [1:0] v);
        @(posedge clk) #5 straps = v;
    endtask
    // reset after a strap change so the new space is latched
    task automatic pulse_ext();
        @(posedge clk) #5 ext_rst_req = 1'b1;
        repeat (3) @(posedge clk);
        #5 ext_rst_req = 1'b0;
    endtask
endmodule

// >>> sim/bss_boot_select_properties.sv
// checker: port properties of the boot space select block
`timescale 1ns/10ps
module bss_boot_select_properties
    import bss_pkg::*;
(
    // clock, reset and requests
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire logic                 ext_rst_req,
    input wire logic                 soft_rst_req,
    input wire logic                 prot_enable_req,
    input wire bss_pkg::bss_straps_t straps,
    // results
    input wire bss_pkg::bss_space_t  boot_space,
    input wire logic [31:0]          fetch_alias_base,
    input wire logic                 core_rst,
    input wire logic                 space_valid
);
    // expected space for a strap pair; primary low always means flash
    function automatic bss_space_t dec(bss_straps_t s);
        return !s.primary_boot_strap ? BSS_SPACE_FLASH :
            s.secondary_boot_strap ? BSS_SPACE_SRAM : BSS_SPACE_SYSMEM;
    endfunction
    function automatic logic [31:0] base(bss_space_t p);
        return p == BSS_SPACE_SRAM ? BSS_BASE_SRAM :
            p == BSS_SPACE_SYSMEM ? BSS_BASE_SYSMEM : BSS_BASE_FLASH;
    endfunction
    // a soft request that the block must honour (running, no hard reset)
    wire soft_ok = !ext_rst_req && !core_rst && space_valid;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    decode_ext_a: assert property (
        $fell(ext_rst_req) |-> core_rst[*3]
        ##[2:4] (!core_rst && boot_space == dec(straps)))
        else $error("strap decode wrong after external reset");
    sysmem_boot_a: assert property (
        $fell(ext_rst_req) && straps == 2'h2
        |-> ##[4:6] boot_space == BSS_SPACE_SYSMEM)
        else $error("no system memory boot");
    soft_pulse_a: assert property (soft_ok && soft_rst_req
        |=> core_rst ##1 !core_rst) else $error("soft reset pulse wrong");
    prot_keep_a: assert property (soft_ok && prot_enable_req
        |=> $stable(boot_space)[*2]) else $error("space moved on prot reset");
    space_hold_a: assert property (
        $changed(boot_space) |-> $fell(core_rst))
        else $error("space changed outside a hard latch");
    alias_map_a: assert property (space_valid
        |-> fetch_alias_base == base(boot_space)) else $error("alias wrong");
    ext_start_a: assert property (ext_rst_req |=> core_rst)
        else $error("core not reset on external reset");
    cover property ($fell(ext_rst_req) ##6 boot_space == BSS_SPACE_SRAM);
    cover property (soft_ok && soft_rst_req);
    cover property (soft_ok && prot_enable_req);
endmodule

bind bss_boot_select bss_boot_select_properties bss_boot_select_properties_inst
(.clk(clk), .sys_rst(sys_rst), .ext_rst_req(ext_rst_req),
 .soft_rst_req(soft_rst_req), .prot_enable_req(prot_enable_req),
 .straps(straps), .boot_space(boot_space),
 .fetch_alias_base(fetch_alias_base),
 .core_rst(core_rst), .space_valid(space_valid));

// >>> sim/test_boot_space_select_on_reset.sv
// testbench: boot space select under hard, soft and protection resets
`timescale 1ns/10ps
module test_boot_space_select_on_reset;
    import bss_pkg::*;
    logic clk = 0, sys_rst = 1, soft_rst_req = 0, prot_enable_req = 0;
    logic ext_rst_req, core_rst, space_valid;
    bss_straps_t straps;
    bss_space_t boot_space;
    logic [31:0] fetch_alias_base;
    int error_cnt = 0, samples_checked = 0;
    always #25 clk = ~clk;
    bss_board_model bss_board_model_inst (.clk(clk), .straps(straps),
        .ext_rst_req(ext_rst_req));
    bss_boot_select bss_boot_select_inst (.clk(clk), .sys_rst(sys_rst),
        .ext_rst_req(ext_rst_req), .soft_rst_req(soft_rst_req),
        .prot_enable_req(prot_enable_req), .straps(straps),
        .boot_space(boot_space), .fetch_alias_base(fetch_alias_base),
        .core_rst(core_rst), .space_valid(space_valid));
    task automatic chk(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // bounded wait until the core leaves reset
    task automatic wait_run();
        repeat (20) begin @(posedge clk); #1; if (core_rst === 1'b0) break; end
    endtask
    // latched space and alias against the strap table
    task automatic chk_space(input logic [1:0] v);
        bss_space_t  exp_space;
        logic [31:0] exp_alias;
        exp_space = !v[1] ? BSS_SPACE_FLASH :
                    v[0] ? BSS_SPACE_SRAM : BSS_SPACE_SYSMEM;
        exp_alias = !v[1] ? BSS_BASE_FLASH :
                    v[0] ? BSS_BASE_SRAM : BSS_BASE_SYSMEM;
        chk("space", exp_space, boot_space);
        chk("alias", exp_alias, fetch_alias_base);
        chk("valid", 1'h1, space_valid);
        chk("core_rst", 1'h0, core_rst);
    endtask
    task automatic t_ext();
        for (int v = 0; v < 4; v++) begin
            bss_board_model_inst.set_straps(v[1:0]);
            bss_board_model_inst.pulse_ext();
            wait_run();
            chk_space(v[1:0]);
        end
        $display("external reset table done");
    endtask
    // soft reset with new straps: short core reset, space kept
    task automatic t_soft();
        bss_board_model_inst.set_straps(2'h0);
        // let the new levels pass the synchroniser, so a resample would show
        repeat (4) @(posedge clk);
        @(posedge clk) #5 soft_rst_req = 1;
        @(posedge clk) #5 soft_rst_req = 0;
        chk("core_rst", 1, core_rst);
        @(posedge clk) #1 chk("core_rst", 0, core_rst);
        chk_space(2'h3);
        $display("soft reset done");
    endtask
    // protection reset from system memory keeps system memory
    task automatic t_prot();
        bss_board_model_inst.set_straps(2'h2);
        bss_board_model_inst.pulse_ext();
        wait_run();
        chk_space(2'h2);
        bss_board_model_inst.set_straps(2'h0);
        // let the new levels pass the synchroniser, so a resample would show
        repeat (4) @(posedge clk);
        @(posedge clk) #5 prot_enable_req = 1;
        @(posedge clk) #5 prot_enable_req = 0;
        chk("core_rst", 1'h1, core_rst);
        wait_run();
        chk_space(2'h2);
        $display("protection reset done");
    endtask
    // power cycle picks up the new straps
    task automatic t_power();
        bss_board_model_inst.set_straps(2'h3);
        @(posedge clk) #5 sys_rst = 1;
        repeat (2) @(posedge clk);
        #1 chk("rst core_rst", 1'h1, core_rst);
        chk("rst valid", 1'h0, space_valid);
        chk("rst space", BSS_SPACE_RST, boot_space);
        chk("rst alias", BSS_BASE_FLASH, fetch_alias_base);
        #4 sys_rst = 0;
        wait_run();
        chk_space(2'h3);
        $display("power cycle done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #5 sys_rst = 0;
        wait_run();
        chk_space(2'h0);
        t_ext();
        t_soft();
        t_prot();
        t_power();
        summarize();
    end
    initial begin
        #20000 error_cnt++;
        summarize();
    end
endmodule
